// ===== hw/mmd_map_decode.sv
// memory map decoder with i/o register page, ram, rom areas and stack pointer
// What this block does
// R1 - 0x20..0xff decode to shared ram and stack
// R2 - interrupt entry pushes five stack bytes
// R3 - subroutine call pushes two stack bytes
// R4 - stack pointer down on push, up on pull
// R5 - software limits nesting; stack may overwrite variables
// R6 - 0x0700..0x1ef7 decode to read-only user rom
// R7 - 0x1ef8..0x1eff decode to read-only security bytes
// R8 - top 16 bytes are vectors plus watchdog service
// R9 - port c registers exist only on large variant
// R10 - port a bits 7:6 read zero
// R11 - timer pairs high byte at lower address
// R12 - compare writable; counters read-only
// R13 - tick timer flags, enables, clear strobes, rate
// R14 - ext interrupt enable, options, flag, clear strobe
// R15 - free counter pair read-only at 0x1a
// R16 - first 32 addresses are the i/o page
// R17 - unused and reserved locations read zero
// R18 - zero bits and read-only fields ignore writes
`timescale 1ns/1ps
`default_nettype none

module mmd_map_decode #(
  parameter bit HAS_PORT_C = 1'b1,
  parameter int ROM_W = 13
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire mmd_pkg::mmd_req_t req_in,
  input wire mmd_pkg::mmd_sp_op_t sp_op_in,
  input wire mmd_pkg::mmd_periph_t periph_in,
  input wire logic [7:0] rom_rdata_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output logic [7:0] sp_out,
  output logic rom_rd_out,
  output logic [ROM_W-1:0] rom_addr_out,
  output logic wdog_service_out,
  output logic tick_ovf_clear_out,
  output logic periodic_clear_out,
  output logic ext_int_clear_out,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_c_pins_out,
  output logic [7:0] port_a_dir_out,
  output logic [7:0] port_b_dir_out,
  output logic [7:0] port_c_dir_out,
  output logic [7:0] analog_sel_out,
  output logic [7:0] tick_ctrl_out,
  output logic [7:0] serial_ctrl_out,
  output logic [7:0] serial_data_out,
  output logic [7:0] ext_ctrl_out,
  output logic [7:0] pd_ac_out,
  output logic [7:0] pd_b_out,
  output logic [7:0] wide_ctrl_out,
  output logic [15:0] compare_out,
  output logic [7:0] analog_ctrl_out,
  output logic [7:0] analog_flag_wr_out
);
  import mmd_pkg::*;

  // ---------------------------------------------------------------
  // area decode
  // ---------------------------------------------------------------
  logic [12:0] a;
  logic [4:0] ofs;
  logic in_io, in_ram, in_rom, in_sec, in_vec, in_wdog;
  logic wr, rd;
  logic [7:0] wd;

  assign a = req_in.addr;
  assign ofs = a[4:0];
  assign wr = req_in.wr;
  assign rd = req_in.rd;
  assign wd = req_in.wdata;
  assign in_io = (a <= IO_LAST); // R16
  assign in_ram = (a >= RAM_BASE) && (a <= RAM_LAST); // R1
  assign in_rom = (a >= ROM_BASE) && (a <= ROM_LAST); // R6
  assign in_sec = (a >= SEC_BASE) && (a <= SEC_LAST); // R7
  assign in_vec = (a >= VEC_BASE); // R8
  assign in_wdog = (a == WDOG_ADDR); // R8

  function automatic logic io_wr(input logic [4:0] o);
    io_wr = wr && in_io && (ofs == o);
  endfunction : io_wr

  // ---------------------------------------------------------------
  // stack ram
  // ---------------------------------------------------------------
  logic [7:0] ram_mem [0:RAM_BYTES-1];
  logic [7:0] ram_idx;
  logic [7:0] ram_q;

  assign ram_idx = 8'(a - RAM_BASE);

  always_ff @(posedge ref_clk_in) begin
    if (wr && in_ram) begin
      ram_mem[ram_idx] <= wd; // R1
    end
    ram_q <= ram_mem[ram_idx];
  end

  // ---------------------------------------------------------------
  // stack pointer
  // ---------------------------------------------------------------
  // core steps once per stacked byte: five for interrupt, two for call
  logic [7:0] sp_r;
  logic [7:0] sp_nxt;

  always_comb begin
    sp_nxt = sp_r;
    case (sp_op_in)
      MMD_SP_PUSH: sp_nxt = SP_FLOOR | 8'(sp_r - 8'h01); // R4 R2 R3
      MMD_SP_PULL: sp_nxt = SP_FLOOR | 8'(sp_r + 8'h01); // R4
      MMD_SP_RESET: sp_nxt = SP_RESET;
      default: sp_nxt = sp_r;
    endcase
  end

  // wraps within the top 64 bytes; deep nesting clobbers data (R5)
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sp_r <= SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end
  assign sp_out = sp_r;

  // ---------------------------------------------------------------
  // port and plain control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      port_a_pins_out <= REG_RESET;
      port_b_pins_out <= REG_RESET;
      port_c_pins_out <= REG_RESET;
      port_a_dir_out <= REG_RESET;
      port_b_dir_out <= REG_RESET;
      port_c_dir_out <= REG_RESET;
      pd_ac_out <= REG_RESET;
      pd_b_out <= REG_RESET;
      analog_sel_out <= REG_RESET;
    end else begin
      if (io_wr(OFS_PORT_A_PINS)) begin
        port_a_pins_out <= wd & PORT_A_MASK; // R10
      end
      if (io_wr(OFS_PORT_B_PINS)) begin
        port_b_pins_out <= wd;
      end
      if (io_wr(OFS_PORT_C_PINS) && HAS_PORT_C) begin
        port_c_pins_out <= wd; // R9
      end
      if (io_wr(OFS_PORT_A_DIRECTION)) begin
        port_a_dir_out <= wd & PORT_A_MASK; // R10
      end
      if (io_wr(OFS_PORT_B_DIRECTION)) begin
        port_b_dir_out <= wd;
      end
      if (io_wr(OFS_PORT_C_DIRECTION) && HAS_PORT_C) begin
        port_c_dir_out <= wd; // R9
      end
      if (io_wr(OFS_PORT_A_C_PULLDOWN_INHIBIT)) begin
        pd_ac_out <= HAS_PORT_C ? wd : (wd & PORT_A_MASK); // R9
      end
      if (io_wr(OFS_PORT_B_PULLDOWN_INHIBIT)) begin
        pd_b_out <= wd;
      end
      if (io_wr(OFS_ANALOG_INPUT_SELECT)) begin
        analog_sel_out <= wd;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      serial_ctrl_out <= REG_RESET;
      serial_data_out <= REG_RESET;
      wide_ctrl_out <= REG_RESET;
      analog_ctrl_out <= REG_RESET;
      compare_out <= 16'h0000;
    end else begin
      if (io_wr(OFS_SERIAL_CONTROL)) serial_ctrl_out <= wd & SER_CTRL_MASK;
      if (io_wr(OFS_SERIAL_SHIFT_DATA)) serial_data_out <= wd;
      if (io_wr(OFS_WIDE_TIMER_CONTROL)) begin
        wide_ctrl_out <= wd & WIDE_CTRL_MASK; // R18
      end
      if (io_wr(OFS_ANALOG_CONTROL)) analog_ctrl_out <= wd;
      if (io_wr(OFS_COMPARE_HIGH)) compare_out[15:8] <= wd; // R11 R12
      if (io_wr(OFS_COMPARE_LOW)) compare_out[7:0] <= wd; // R12
    end
  end

  // ---------------------------------------------------------------
  // tick timer and external interrupt flags
  // ---------------------------------------------------------------
  logic tick_ovf_r, periodic_r, ext_flag_r;
  logic [7:0] tick_rw_r, ext_rw_r;
  logic tk_clr_o, tk_clr_p, ex_clr;

  // written out so each assign is sensitive to wr, in_io and ofs
  assign tk_clr_o = wr && in_io && (ofs == OFS_TICK_TIMER_CTRL_STAT)
    && wd[TICK_OVF_CLR_BIT];
  assign tk_clr_p = wr && in_io && (ofs == OFS_TICK_TIMER_CTRL_STAT)
    && wd[TICK_PER_CLR_BIT];
  assign ex_clr = wr && in_io && (ofs == OFS_EXT_INTERRUPT_CTRL_STAT)
    && wd[EXT_CLR_BIT];

  // set beats a clear in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tick_ovf_r <= 1'b0;
      periodic_r <= 1'b0;
      ext_flag_r <= 1'b0;
      tick_rw_r <= REG_RESET;
      ext_rw_r <= REG_RESET;
    end else begin
      tick_ovf_r <= periph_in.tick_ovf_set | (tick_ovf_r & ~tk_clr_o); // R13
      periodic_r <= periph_in.periodic_set | (periodic_r & ~tk_clr_p); // R13
      ext_flag_r <= periph_in.ext_int_set | (ext_flag_r & ~ex_clr); // R14
      if (io_wr(OFS_TICK_TIMER_CTRL_STAT)) begin
        tick_rw_r <= wd & TICK_RW_MASK; // R13
      end
      if (io_wr(OFS_EXT_INTERRUPT_CTRL_STAT)) begin
        ext_rw_r <= wd & EXT_RW_MASK; // R14
      end
    end
  end

  // strobes out to the peripherals, one cycle wide; tick and ext control outputs held as levels
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tick_ovf_clear_out <= 1'b0;
      periodic_clear_out <= 1'b0;
      ext_int_clear_out <= 1'b0;
      wdog_service_out <= 1'b0;
      analog_flag_wr_out <= REG_RESET;
      tick_ctrl_out <= REG_RESET;
      ext_ctrl_out <= REG_RESET;
    end else begin
      tick_ovf_clear_out <= tk_clr_o; // R13
      periodic_clear_out <= tk_clr_p; // R13
      ext_int_clear_out <= ex_clr; // R14
      wdog_service_out <= wr && in_wdog; // R8
      analog_flag_wr_out <= io_wr(OFS_ANALOG_FLAGS) ? (wd & ANA_FLAG_WR_MASK)
                                                    : REG_RESET;
      tick_ctrl_out <= io_wr(OFS_TICK_TIMER_CTRL_STAT) ? (wd & TICK_RW_MASK)
                                                       : tick_rw_r;
      ext_ctrl_out <= io_wr(OFS_EXT_INTERRUPT_CTRL_STAT) ? (wd & EXT_RW_MASK)
                                                         : ext_rw_r;
    end
  end

  // ---------------------------------------------------------------
  // i/o page read mux
  // ---------------------------------------------------------------
  logic [7:0] io_q;

  always_comb begin
    io_q = 8'h00; // R17 R18
    if (ofs == OFS_PORT_A_PINS) begin
      io_q = port_a_pins_out & PORT_A_MASK; // R10
    end
    else if (ofs == OFS_PORT_B_PINS) begin
      io_q = port_b_pins_out;
    end
    else if (ofs == OFS_PORT_C_PINS) begin
      io_q = HAS_PORT_C ? port_c_pins_out : 8'h00; // R9
    end
    else if (ofs == OFS_ANALOG_INPUT_SELECT) begin
      io_q = analog_sel_out;
    end
    else if (ofs == OFS_PORT_A_DIRECTION) begin
      io_q = port_a_dir_out & PORT_A_MASK; // R10
    end
    else if (ofs == OFS_PORT_B_DIRECTION) begin
      io_q = port_b_dir_out;
    end
    else if (ofs == OFS_PORT_C_DIRECTION) begin
      io_q = HAS_PORT_C ? port_c_dir_out : 8'h00; // R9
    end
    else if (ofs == OFS_TICK_TIMER_CTRL_STAT) begin
      io_q = {tick_ovf_r, periodic_r, 6'h00} | tick_rw_r; // R13
    end
    else if (ofs == OFS_TICK_TIMER_COUNT) begin
      io_q = periph_in.tick_count;
    end
    else if (ofs == OFS_SERIAL_CONTROL) begin
      io_q = serial_ctrl_out;
    end
    else if (ofs == OFS_SERIAL_FLAGS) begin
      io_q = periph_in.serial_flags & TICK_FLAG_MASK;
    end
    else if (ofs == OFS_SERIAL_SHIFT_DATA) begin
      io_q = serial_data_out;
    end
    else if (ofs == OFS_EXT_INTERRUPT_CTRL_STAT) begin
      io_q = ext_rw_r | (8'(ext_flag_r) << EXT_FLAG_BIT); // R14
    end
    else if (ofs == OFS_WIDE_TIMER_CONTROL) begin
      io_q = wide_ctrl_out;
    end
    else if (ofs == OFS_WIDE_TIMER_FLAGS) begin
      io_q = periph_in.wide_flags & 8'he0;
    end
    else if (ofs == OFS_CAPTURE_HIGH) begin
      io_q = periph_in.capture[15:8]; // R11
    end
    else if (ofs == OFS_CAPTURE_LOW) begin
      io_q = periph_in.capture[7:0]; // R11
    end
    else if (ofs == OFS_COMPARE_HIGH) begin
      io_q = compare_out[15:8]; // R11
    end
    else if (ofs == OFS_COMPARE_LOW) begin
      io_q = compare_out[7:0];
    end
    else if (ofs == OFS_COUNTER_HIGH) begin
      io_q = periph_in.counter[15:8]; // R12
    end
    else if (ofs == OFS_COUNTER_LOW) begin
      io_q = periph_in.counter[7:0]; // R12
    end
    else if (ofs == OFS_FREE_COUNTER_HIGH) begin
      io_q = periph_in.free_counter[15:8]; // R15
    end
    else if (ofs == OFS_FREE_COUNTER_LOW) begin
      io_q = periph_in.free_counter[7:0]; // R15
    end
    else if (ofs == OFS_ANALOG_CONTROL) begin
      io_q = analog_ctrl_out;
    end
    else if (ofs == OFS_ANALOG_FLAGS) begin
      io_q = periph_in.analog_flags & ANA_FLAG_RD_MASK;
    end
    else begin
      io_q = 8'h00; // R17
    end
  end

  // ---------------------------------------------------------------
  // read pipeline: request in cycle 0, data in cycle 1
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MMD_SRC_NONE = 3'b000,
    MMD_SRC_IO = 3'b001,
    MMD_SRC_RAM = 3'b010,
    MMD_SRC_ROM = 3'b011
  } mmd_src_t;

  mmd_src_t src_r;
  logic [7:0] io_hold_r;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      src_r <= MMD_SRC_NONE;
      io_hold_r <= REG_RESET;
      rdata_valid_out <= 1'b0;
      rom_rd_out <= 1'b0;
      rom_addr_out <= '0;
    end else begin
      rdata_valid_out <= rd;
      io_hold_r <= io_q;
      rom_rd_out <= rd && (in_rom || in_sec || in_vec); // R6 R7 R8
      rom_addr_out <= a[ROM_W-1:0];
      if (!rd) src_r <= MMD_SRC_NONE;
      else if (in_io) src_r <= MMD_SRC_IO;
      else if (in_ram) src_r <= MMD_SRC_RAM;
      else if (in_rom || in_sec || in_vec) src_r <= MMD_SRC_ROM;
      else src_r <= MMD_SRC_NONE;
    end
  end

  // rom data arrives with the same one-cycle latency as the rom_rd strobe
  always_comb begin
    case (src_r)
      MMD_SRC_IO: rdata_out = io_hold_r;
      MMD_SRC_RAM: rdata_out = ram_q;
      MMD_SRC_ROM: rdata_out = rom_rdata_in;
      default: rdata_out = 8'h00;
    endcase
  end

endmodule : mmd_map_decode

`default_nettype wire

// ===== hw/mmd_pkg.sv
// package: memory map constants and bus carrier types for the map decoder
package mmd_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // i/o page
  localparam logic [12:0] IO_BASE = 13'h0000;
  localparam logic [12:0] IO_LAST = 13'h001f;
  localparam logic [4:0] OFS_PORT_A_PINS = 5'h00;
  localparam logic [4:0] OFS_PORT_B_PINS = 5'h01;
  localparam logic [4:0] OFS_PORT_C_PINS = 5'h02;
  localparam logic [4:0] OFS_ANALOG_INPUT_SELECT = 5'h03;
  localparam logic [4:0] OFS_PORT_A_DIRECTION = 5'h04;
  localparam logic [4:0] OFS_PORT_B_DIRECTION = 5'h05;
  localparam logic [4:0] OFS_PORT_C_DIRECTION = 5'h06;
  localparam logic [4:0] OFS_UNUSED_07 = 5'h07;
  localparam logic [4:0] OFS_TICK_TIMER_CTRL_STAT = 5'h08;
  localparam logic [4:0] OFS_TICK_TIMER_COUNT = 5'h09;
  localparam logic [4:0] OFS_SERIAL_CONTROL = 5'h0a;
  localparam logic [4:0] OFS_SERIAL_FLAGS = 5'h0b;
  localparam logic [4:0] OFS_SERIAL_SHIFT_DATA = 5'h0c;
  localparam logic [4:0] OFS_EXT_INTERRUPT_CTRL_STAT = 5'h0d;
  localparam logic [4:0] OFS_UNUSED_0E = 5'h0e;
  localparam logic [4:0] OFS_UNUSED_0F = 5'h0f;
  localparam logic [4:0] OFS_PORT_A_C_PULLDOWN_INHIBIT = 5'h10;
  localparam logic [4:0] OFS_PORT_B_PULLDOWN_INHIBIT = 5'h11;
  localparam logic [4:0] OFS_WIDE_TIMER_CONTROL = 5'h12;
  localparam logic [4:0] OFS_WIDE_TIMER_FLAGS = 5'h13;
  localparam logic [4:0] OFS_CAPTURE_HIGH = 5'h14;
  localparam logic [4:0] OFS_CAPTURE_LOW = 5'h15;
  localparam logic [4:0] OFS_COMPARE_HIGH = 5'h16;
  localparam logic [4:0] OFS_COMPARE_LOW = 5'h17;
  localparam logic [4:0] OFS_COUNTER_HIGH = 5'h18;
  localparam logic [4:0] OFS_COUNTER_LOW = 5'h19;
  localparam logic [4:0] OFS_FREE_COUNTER_HIGH = 5'h1a;
  localparam logic [4:0] OFS_FREE_COUNTER_LOW = 5'h1b;
  localparam logic [4:0] OFS_UNUSED_1C = 5'h1c;
  localparam logic [4:0] OFS_ANALOG_CONTROL = 5'h1d;
  localparam logic [4:0] OFS_ANALOG_FLAGS = 5'h1e;
  localparam logic [4:0] OFS_RESERVED_LOCATION = 5'h1f;

  // memory areas
  localparam logic [12:0] RAM_BASE = 13'h0020;
  localparam logic [12:0] RAM_LAST = 13'h00ff;
  localparam int RAM_BYTES = 224;
  localparam logic [12:0] ROM_BASE = 13'h0700;
  localparam logic [12:0] ROM_LAST = 13'h1ef7;
  localparam int ROM_BYTES = 6136;
  localparam logic [12:0] SEC_BASE = 13'h1ef8;
  localparam logic [12:0] SEC_LAST = 13'h1eff;
  localparam int SEC_BYTES = 8;
  localparam logic [12:0] VEC_BASE = 13'h1ff0;
  localparam logic [12:0] VEC_LAST = 13'h1fff;
  localparam int VEC_BYTES = 16;
  localparam logic [12:0] WDOG_ADDR = 13'h1ff0;

  // stack
  localparam logic [7:0] SP_RESET = 8'hff;
  localparam logic [7:0] SP_FLOOR = 8'hc0;
  localparam int INT_PUSH_BYTES = 5;
  localparam int CALL_PUSH_BYTES = 2;

  // field positions
  localparam logic [7:0] PORT_A_MASK = 8'h3f;
  localparam logic [7:0] TICK_FLAG_MASK = 8'hc0;
  localparam logic [7:0] TICK_RW_MASK = 8'h33;
  localparam int TICK_OVF_CLR_BIT = 3;
  localparam int TICK_PER_CLR_BIT = 2;
  localparam logic [7:0] EXT_RW_MASK = 8'he0;
  localparam int EXT_FLAG_BIT = 3;
  localparam int EXT_CLR_BIT = 1;
  localparam logic [7:0] SER_CTRL_MASK = 8'hf7;
  localparam logic [7:0] WIDE_CTRL_MASK = 8'he3;
  localparam logic [7:0] ANA_FLAG_RD_MASK = 8'hc3;
  localparam logic [7:0] ANA_FLAG_WR_MASK = 8'h0c;
  localparam logic [7:0] REG_RESET = 8'h00;

  // stack command from the core
  typedef enum logic [1:0] {
    MMD_SP_NONE = 2'b00,
    MMD_SP_PUSH = 2'b01,
    MMD_SP_PULL = 2'b10,
    MMD_SP_RESET = 2'b11
  } mmd_sp_op_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [12:0] addr;
    logic [7:0] wdata;
  } mmd_req_t;

  // peripheral state flowing into the page
  typedef struct packed {
    logic tick_ovf_set;
    logic periodic_set;
    logic ext_int_set;
    logic [7:0] tick_count;
    logic [7:0] serial_flags;
    logic [7:0] wide_flags;
    logic [15:0] capture;
    logic [15:0] counter;
    logic [15:0] free_counter;
    logic [7:0] analog_flags;
  } mmd_periph_t;

endpackage : mmd_pkg

// ===== tb/mmd_rom_model.sv
// partner: program memory answering the decoder's fetch strobe
`timescale 1ns/1ps
`default_nettype none

module mmd_rom_model #(
  parameter int ROM_W = 13
) (
  input wire logic ref_clk_in,
  input wire logic rom_rd_in,
  input wire logic [ROM_W-1:0] rom_addr_in,
  output logic [7:0] rom_rdata_out
);
  logic [7:0] idle_r = 8'h5a;

  // idle bus toggles every cycle so stale data never passes
  always_ff @(posedge ref_clk_in) begin
    idle_r <= ~idle_r;
  end

  always_comb begin
    rom_rdata_out = idle_r;
    if (rom_rd_in) begin
      rom_rdata_out = rom_addr_in[7:0] ^ 8'(rom_addr_in >> 8) ^ 8'h3c;
    end
  end
endmodule : mmd_rom_model

`default_nettype wire

// ===== tb/mmd_map_decode_asserts.sv
// checker: port-level properties of the memory map decoder
`timescale 1ns/1ps
`default_nettype none

module mmd_map_decode_asserts #(
  parameter int ROM_W = 13
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire mmd_pkg::mmd_req_t req_in,
  input wire mmd_pkg::mmd_sp_op_t sp_op_in,
  input wire logic [7:0] rdata_out,
  input wire logic rdata_valid_out,
  input wire logic [7:0] sp_out,
  input wire logic rom_rd_out,
  input wire logic [ROM_W-1:0] rom_addr_out,
  input wire logic wdog_service_out,
  input wire logic tick_ovf_clear_out,
  input wire logic ext_int_clear_out,
  input wire logic [7:0] tick_ctrl_out,
  input wire logic [15:0] compare_out
);
  import mmd_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic rom_hit;
  logic io_zero;
  mmd_req_t prev_r;
  assign rom_hit = (req_in.addr >= ROM_BASE && req_in.addr <= SEC_LAST)
    || req_in.addr >= VEC_BASE;
  assign io_zero = req_in.addr inside {13'h0007, 13'h000e, 13'h000f,
    13'h001c, 13'h001f};

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prev_r <= '0;
    end else begin
      prev_r <= req_in;
    end
  end

  a_read_answer: assert property (req_in.rd |=> rdata_valid_out)
    else $error("read not answered next cycle");
  a_rom_fetch: assert property (req_in.rd && rom_hit |=> rom_rd_out
    && rom_addr_out == prev_r.addr[ROM_W-1:0])
    else $error("rom fetch missing");
  a_ram_no_rom: assert property (req_in.rd && req_in.addr <= RAM_LAST
    |=> !rom_rd_out) else $error("rom fetch on low page");
  a_wdog_pulse: assert property (wdog_service_out ==
    (prev_r.wr && prev_r.addr == WDOG_ADDR)) else $error("watchdog pulse");
  a_sp_push: assert property (sp_op_in == MMD_SP_PUSH |=> sp_out ==
    (($past(sp_out) == SP_FLOOR) ? SP_RESET : $past(sp_out) - 8'h01))
    else $error("push step wrong");
  a_sp_pull: assert property (sp_op_in == MMD_SP_PULL && sp_out != SP_RESET
    |=> sp_out == $past(sp_out) + 8'h01) else $error("pull step wrong");
  a_sp_hold: assert property (sp_op_in == MMD_SP_NONE |=> $stable(sp_out))
    else $error("stack pointer moved");
  a_zero_bits: assert property (rdata_valid_out && !prev_r.addr[12:3]
    && prev_r.addr[1:0] == 2'b00 |-> rdata_out[7:6] == 2'b00)
    else $error("port a top bits set");
  a_unused_zero: assert property (req_in.rd && io_zero |=> rdata_out == 8'h00)
    else $error("unused location not zero");
  a_compare_hi: assert property (req_in.wr && req_in.addr == 13'h0016
    |=> compare_out[15:8] == prev_r.wdata) else $error("compare high");
  a_tick_strobe: assert property (tick_ovf_clear_out == (prev_r.wr
    && prev_r.addr == 13'h0008 && prev_r.wdata[3])) else $error("tick clear");
  a_tick_fields: assert property (req_in.wr && req_in.addr == 13'h0008
    |=> tick_ctrl_out == (prev_r.wdata & TICK_RW_MASK)) else $error("tick rw");
  a_ext_strobe: assert property (req_in.wr && req_in.addr == 13'h000d
    && req_in.wdata[1] |=> ext_int_clear_out) else $error("ext clear");
endmodule : mmd_map_decode_asserts

`default_nettype wire

// ===== tb/mmd_map_decode_tb.sv
// testbench: register page, memory areas and stack of the map decoder
`timescale 1ns/1ps
`default_nettype none

module mmd_map_decode_tb;
  import mmd_pkg::*;
  localparam int ROM_W = 13;
  logic ref_clk_in;
  logic sys_rst_in;
  mmd_req_t req;
  mmd_sp_op_t sp_op;
  mmd_periph_t periph;
  logic [7:0] rom_rdata, rdata, sp, d;
  logic rdata_valid, rom_rd, wdog, tclr, pclr, eclr;
  logic [ROM_W-1:0] rom_addr;
  logic [15:0] compare;
  logic [7:0] pd_ac, pd_b, afw;
  int n_fail = 0;
  int check_count = 0;
  logic [12:0] rom_tbl [6] = '{13'h0700, 13'h1ef7, 13'h1ef8, 13'h1eff,
    13'h1ff0, 13'h1fff};
  logic [12:0] un_tbl [5] = '{13'h0007, 13'h000e, 13'h000f, 13'h001c,
    13'h001f};

  mmd_map_decode #(.HAS_PORT_C(1'b1), .ROM_W(ROM_W)) dut_u (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .sp_op_in(sp_op), .periph_in(periph), .rom_rdata_in(rom_rdata),
    .rdata_out(rdata), .rdata_valid_out(rdata_valid), .sp_out(sp),
    .rom_rd_out(rom_rd), .rom_addr_out(rom_addr), .wdog_service_out(wdog),
    .tick_ovf_clear_out(tclr), .periodic_clear_out(pclr),
    .ext_int_clear_out(eclr), .port_a_pins_out(), .port_b_pins_out(),
    .port_c_pins_out(), .port_a_dir_out(), .port_b_dir_out(),
    .port_c_dir_out(), .analog_sel_out(), .tick_ctrl_out(),
    .serial_ctrl_out(), .serial_data_out(), .ext_ctrl_out(), .pd_ac_out(pd_ac),
    .pd_b_out(pd_b), .wide_ctrl_out(), .compare_out(compare),
    .analog_ctrl_out(), .analog_flag_wr_out(afw));

  mmd_rom_model #(.ROM_W(ROM_W)) rom_u (.ref_clk_in(ref_clk_in),
    .rom_rd_in(rom_rd), .rom_addr_in(rom_addr), .rom_rdata_out(rom_rdata));

  function automatic logic [7:0] rom_byte(input logic [12:0] a);
    return a[7:0] ^ {3'b000, a[12:8]} ^ 8'h3c;
  endfunction : rom_byte

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge ref_clk_in);
    req <= '0;
    #1;
  endtask : wr

  task automatic rc(input logic [12:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk_in);
    req <= '0;
    #1;
    chk(16'(rdata_valid), 16'h0001);
    chk(16'(rdata), 16'(exp));
  endtask : rc

  task automatic sp_run(input mmd_sp_op_t op, input int n);
    @(posedge ref_clk_in);
    sp_op <= op;
    repeat (n) @(posedge ref_clk_in);
    sp_op <= MMD_SP_NONE;
    #1;
  endtask : sp_run

  task automatic set_pulse(input int k);
    @(posedge ref_clk_in);
    periph.tick_ovf_set <= (k == 0);
    periph.periodic_set <= (k == 1);
    periph.ext_int_set <= (k == 2);
    @(posedge ref_clk_in);
    periph.tick_ovf_set <= 1'b0;
    periph.periodic_set <= 1'b0;
    periph.ext_int_set <= 1'b0;
  endtask : set_pulse

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    $display("ERROR at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    req = '0;
    sp_op = MMD_SP_NONE;
    periph = '0;
    periph.capture = 16'hc1c2;
    periph.counter = 16'h1718;
    periph.free_counter = 16'ha1a2;
    periph.tick_count = 8'h96;
    periph.serial_flags = 8'hff;
    periph.wide_flags = 8'hff;
    periph.analog_flags = 8'hff;
    sys_rst_in = 1'b1;
    repeat (20) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk(16'(sp), 16'(SP_RESET));
    rc(13'h0000, 8'h00);
    $display("test reset done");
    wr(13'h0020, 8'h5a);
    wr(13'h00ff, 8'ha5);
    rc(13'h0020, 8'h5a);
    rc(13'h00ff, 8'ha5);
    wr(13'h0100, 8'h77);
    rc(13'h0100, 8'h00);
    $display("test ram done");
    foreach (rom_tbl[i]) begin
      wr(rom_tbl[i], 8'hff);
      rc(rom_tbl[i], rom_byte(rom_tbl[i]));
    end
    wr(WDOG_ADDR, 8'h00);
    chk(16'(wdog), 16'h0001);
    rc(13'h06ff, 8'h00);
    rc(13'h1f00, 8'h00);
    $display("test rom done");
    wr(13'h0000, 8'hff);
    rc(13'h0000, 8'h3f);
    wr(13'h0004, 8'hff);
    rc(13'h0004, 8'h3f);
    wr(13'h0001, 8'ha5);
    rc(13'h0001, 8'ha5);
    wr(13'h0002, 8'h5a);
    rc(13'h0002, 8'h5a);
    wr(13'h0006, 8'hc3);
    rc(13'h0006, 8'hc3);
    wr(13'h0016, 8'h12);
    wr(13'h0017, 8'h34);
    chk(compare, 16'h1234);
    rc(13'h0016, 8'h12);
    wr(13'h0018, 8'hff);
    rc(13'h0018, 8'h17);
    rc(13'h0019, 8'h18);
    rc(13'h0014, 8'hc1);
    rc(13'h0015, 8'hc2);
    rc(13'h001a, 8'ha1);
    rc(13'h001b, 8'ha2);
    rc(13'h0009, 8'h96);
    rc(13'h000b, 8'hc0);
    rc(13'h0013, 8'he0);
    rc(13'h001e, 8'hc3);
    wr(13'h001e, 8'hff);
    chk(16'(afw), 16'h000c);
    wr(13'h0010, 8'hff);
    chk(16'(pd_ac), 16'h00ff);
    wr(13'h0011, 8'h96);
    chk(16'(pd_b), 16'h0096);
    wr(13'h0003, 8'h69);
    rc(13'h0003, 8'h69);
    wr(13'h000a, 8'hff);
    rc(13'h000a, 8'hf7);
    wr(13'h000c, 8'hc5);
    rc(13'h000c, 8'hc5);
    wr(13'h0012, 8'hff);
    rc(13'h0012, 8'he3);
    wr(13'h001d, 8'h3c);
    rc(13'h001d, 8'h3c);
    foreach (un_tbl[i]) begin
      wr(un_tbl[i], 8'hff);
      rc(un_tbl[i], 8'h00);
    end
    $display("test io page done");
    set_pulse(0);
    rc(13'h0008, 8'h80);
    wr(13'h0008, 8'hff);
    chk(16'(tclr), 16'h0001);
    rc(13'h0008, 8'h33);
    set_pulse(1);
    rc(13'h0008, 8'h73);
    wr(13'h0008, 8'h37);
    chk(16'(pclr), 16'h0001);
    rc(13'h0008, 8'h33);
    set_pulse(2);
    rc(13'h000d, 8'h08);
    wr(13'h000d, 8'hf2);
    chk(16'(eclr), 16'h0001);
    rc(13'h000d, 8'he0);
    $display("test flags done");
    sp_run(MMD_SP_PUSH, INT_PUSH_BYTES);
    chk(16'(sp), 16'h00fa);
    sp_run(MMD_SP_PULL, INT_PUSH_BYTES);
    chk(16'(sp), 16'h00ff);
    sp_run(MMD_SP_PUSH, CALL_PUSH_BYTES);
    chk(16'(sp), 16'h00fd);
    sp_run(MMD_SP_RESET, 1);
    chk(16'(sp), 16'h00ff);
    // nesting past 64 bytes wraps onto older data
    sp_run(MMD_SP_PUSH, 64);
    chk(16'(sp), 16'h00ff);
    $display("test stack done");
    wrap_up();
  end
endmodule : mmd_map_decode_tb

bind mmd_map_decode mmd_map_decode_asserts #(.ROM_W(ROM_W)) chk_u (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
  .sp_op_in(sp_op_in), .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out), .sp_out(sp_out),
  .rom_rd_out(rom_rd_out), .rom_addr_out(rom_addr_out),
  .wdog_service_out(wdog_service_out),
  .tick_ovf_clear_out(tick_ovf_clear_out),
  .ext_int_clear_out(ext_int_clear_out), .tick_ctrl_out(tick_ctrl_out),
  .compare_out(compare_out));

`default_nettype wire
